// ===== verilog/adc_serial_consts.vh
// Constants for the converter serial control block
`ifndef ADC_SERIAL_CONSTS_VH
`define ADC_SERIAL_CONSTS_VH
`define CTRL_START_BIT 7
`define CTRL_SEL_HI 6
`define CTRL_SEL_LO 4
`define CTRL_POLARITY_BIT 3
`define CTRL_CONFIG_BIT 2
`define CTRL_PCS_HI 1
`define CTRL_PCS_LO 0
`define PCS_FULL_PD 2'h0
`define PCS_FAST_PD 2'h1
`define PCS_INT_CLK 2'h2
`define PCS_EXT_CLK 2'h3
`define RESULT_BITS 10
`define DECISION_BITS 12
`define TRACK_START_BIT 5
`define CTRL_BITS 8
`define INT_CONV_CLKS 8'h0C
`define FIFO_DEPTH 32
`endif

// ===== verilog/result_fifo.v
// Synchronous FIFO holding conversion results
`timescale 1ns/1ns
`default_nettype none
module result_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output reg [WIDTH-1:0] out_data,
    output reg out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_q;
    reg [AW:0] rd_q;
    wire [AW:0] count = wr_q - rd_q;
    localparam [AW:0] DEPTH_W = DEPTH;
    wire full = (count == DEPTH_W);
    wire empty = (count == {(AW+1){1'b0}});
    wire pop = !empty && (!out_valid || out_ready);
    wire push = in_valid && !full;
    assign in_ready = !full;

    always @(posedge clk)
    begin
        if (push)
            mem[wr_q[AW-1:0]] <= in_data;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
                out_data <= mem[rd_q[AW-1:0]];
                out_valid <= 1'b1;
            end
            else if (out_ready)
                out_valid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== verilog/adc_serial_control.v
// Serial control, track/hold and SAR sequencing of an 8-channel 10-bit converter
// Operation
// [R1] serial_out changes only on clock falling edges
// [R2] serial_out high impedance while select_n high
// [R3] Internal mode: strobe low during conversion
// [R4] External mode: strobe high one period before MSB
// [R5] External mode: strobe high impedance when deselected
// [R6] serial_in sampled on clock rising edges
// [R7] serial_in ignored while select_n high
// [R8] Host keeps clock duty 40 to 60 percent
// [R9] Conversion yields 10-bit successive-approximation result
// [R10] Single-ended: channel positive, negative to ground
// [R11] Differential: fixed adjacent pairs 0/1..6/7
// [R12] Acquisition three cycles, ends after last bit
// [R13] Track after bit five, hold after eight
// [R14] Reconnect capacitor to positive input when done
// [R15] Control byte MSB first, documented field layout
// [R16] First one after select falls is bit 7
// [R17] Host uses unipolar with single-ended input
// [R18] Differential unipolar negative input gives zero
// [R19] Single-ended channel code mapping table
// [R20] Differential pair mapping, upper codes swapped
// [R21] Conversion starts on falling edge after bit 8
// [R22] External mode shifts twelve decisions out
// [R23] Unipolar straight binary, bipolar two's complement
// [R24] Host sends 1XXXXX11 for external mode
// [R25] Power/clock encoding: 00,01,10,11 modes
// [R26] Zeros before start marker are ignored
`timescale 1ns/1ns
`default_nettype none
`include "adc_serial_consts.vh"
module adc_serial_control #(
    parameter DEPTH = `FIFO_DEPTH
) (
    input wire clk,
    input wire rst_n,
    input wire serial_clk,
    input wire select_n,
    input wire serial_in,
    output reg serial_out,
    output reg serial_out_oe_n,
    output reg conv_strobe,
    output reg conv_strobe_oe_n,
    // Comparator answer for the trial code on dac_code
    input wire comp_above,
    output reg [9:0] dac_code,
    output reg [3:0] pos_input,
    output reg [3:0] neg_input,
    output reg neg_is_ground,
    output reg track_hold,
    output reg cap_on_pos,
    output reg [2:0] channel_sel,
    output reg polarity_sel,
    output reg input_config_sel,
    output reg [1:0] power_clock_sel,
    output reg powered_down,
    output reg [11:0] result_data,
    output reg result_valid,
    input wire result_ready
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_CTRL = 4'b0010;
    localparam ST_CONV = 4'b0100;
    localparam ST_SHIFT = 4'b1000;

    reg [2:0] sclk_sync_q;
    reg [1:0] sel_sync_q;
    reg [1:0] din_sync_q;
    reg [3:0] state_q;
    reg [7:0] shreg_q;
    reg [3:0] bitcnt_q;
    reg [3:0] step_q;
    reg [11:0] sar_q;
    reg [11:0] out_q;
    reg [3:0] outcnt_q;
    reg ext_mode_q;
    reg fifo_in_valid_q;
    reg [11:0] fifo_in_data_q;
    reg [7:0] int_cnt_q;

    wire sclk_s = sclk_sync_q[1];
    wire sclk_rise = sclk_s && !sclk_sync_q[2];
    wire sclk_fall = !sclk_s && sclk_sync_q[2];
    wire sel_n_s = sel_sync_q[1];
    wire din_s = din_sync_q[1];
    wire fifo_in_ready;
    wire [11:0] fifo_out_data;
    wire fifo_out_valid;
    // Output stage takes a word when its own slot is free or being read this cycle
    wire fifo_out_ready = !result_valid || result_ready;

    // Single-ended code to channel: bit 2 picks odd, bits 1:0 pick pair
    function [3:0] se_channel;
        input [2:0] code;
        begin
            se_channel = {1'b0, code[1:0], code[2]}; // [R19]
        end
    endfunction

    // One SAR step: settle the tried bit, then try the next lower one
    function [9:0] next_dac;
        input [9:0] code;
        input [3:0] step;
        input above;
        begin
            next_dac = (code & ~(10'h200 >> step))
                | (above ? (10'h200 >> step) : 10'h000)
                | (10'h100 >> step); // [R9]
        end
    endfunction

    // Fed from the raw pins; sampled by our own clock only
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_sync_q <= 3'h0;
            sel_sync_q <= 2'h3;
            din_sync_q <= 2'h0;
        end
        else
        begin
            sclk_sync_q <= {sclk_sync_q[1], sclk_sync_q[0], serial_clk};
            sel_sync_q <= {sel_sync_q[0], select_n};
            din_sync_q <= {din_sync_q[0], serial_in};
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            shreg_q <= 8'h00;
            bitcnt_q <= 4'h0;
            step_q <= 4'h0;
            sar_q <= 12'h000;
            out_q <= 12'h000;
            outcnt_q <= 4'h0;
            ext_mode_q <= 1'b0;
            int_cnt_q <= 8'h00;
            fifo_in_valid_q <= 1'b0;
            fifo_in_data_q <= 12'h000;
            serial_out <= 1'b0;
            serial_out_oe_n <= 1'b1;
            conv_strobe <= 1'b1;
            conv_strobe_oe_n <= 1'b1;
            dac_code <= 10'h000;
            pos_input <= 4'h0;
            neg_input <= 4'h0;
            neg_is_ground <= 1'b1;
            track_hold <= 1'b0;
            cap_on_pos <= 1'b1;
            channel_sel <= 3'h0;
            polarity_sel <= 1'b1;
            input_config_sel <= 1'b1;
            power_clock_sel <= `PCS_INT_CLK;
            powered_down <= 1'b0;
        end
        else
        begin
            if (fifo_in_valid_q && fifo_in_ready)
                fifo_in_valid_q <= 1'b0;
            serial_out_oe_n <= sel_n_s; // [R2]
            if (ext_mode_q)
                conv_strobe_oe_n <= sel_n_s; // [R5]
            else
                conv_strobe_oe_n <= 1'b0;
            // Control byte framing, reading only while selected
            if (sclk_rise && !sel_n_s) // [R6] [R7]
            begin
                if (state_q == ST_IDLE || state_q == ST_SHIFT)
                begin
                    if (din_s) // [R16] [R26]
                    begin
                        shreg_q <= 8'h01;
                        bitcnt_q <= 4'h1;
                        state_q <= ST_CTRL;
                    end
                end
                else if (state_q == ST_CTRL && bitcnt_q < `CTRL_BITS)
                begin
                    shreg_q <= {shreg_q[6:0], din_s}; // [R15]
                    bitcnt_q <= bitcnt_q + 4'h1;
                end
            end
            if (sclk_fall)
            begin
                case (state_q)
                    ST_CTRL:
                    begin
                        if (bitcnt_q == `TRACK_START_BIT)
                        begin
                            track_hold <= 1'b1; // [R13] [R12]
                            cap_on_pos <= 1'b1;
                            channel_sel <= shreg_q[3:1];
                            pos_input <= se_channel(shreg_q[3:1]);
                        end
                        if (bitcnt_q == 4'd7)
                        begin
                            input_config_sel <= shreg_q[1];
                            if (shreg_q[1])
                            begin
                                neg_is_ground <= 1'b1; // [R10]
                                pos_input <= se_channel(channel_sel);
                            end
                            else
                            begin
                                neg_is_ground <= 1'b0; // [R11] [R20]
                                pos_input <= {1'b0, channel_sel[1:0], channel_sel[2]};
                                neg_input <= {1'b0, channel_sel[1:0], !channel_sel[2]};
                            end
                            polarity_sel <= shreg_q[2];
                        end
                        if (bitcnt_q == `CTRL_BITS)
                        begin
                            // Hold and start on the falling edge after bit 8
                            track_hold <= 1'b0; // [R13] [R21]
                            cap_on_pos <= 1'b0;
                            power_clock_sel <= shreg_q[1:0]; // [R25]
                            case (shreg_q[1:0])
                                `PCS_EXT_CLK:
                                begin
                                    ext_mode_q <= 1'b1;
                                    conv_strobe <= 1'b1; // [R4]
                                    powered_down <= 1'b0;
                                end
                                `PCS_INT_CLK:
                                begin
                                    ext_mode_q <= 1'b0;
                                    conv_strobe <= 1'b0; // [R3]
                                    powered_down <= 1'b0;
                                end
                                default:
                                begin
                                    ext_mode_q <= 1'b0;
                                    conv_strobe <= 1'b0; // [R3]
                                    powered_down <= 1'b1;
                                end
                            endcase
                            sar_q <= 12'h000;
                            dac_code <= 10'h200;
                            step_q <= 4'h0;
                            int_cnt_q <= 8'h00;
                            state_q <= ST_CONV;
                        end
                    end
                    ST_CONV:
                    begin
                        if (ext_mode_q)
                        begin
                            // SAR decision, presented at once on serial_out
                            conv_strobe <= 1'b0; // [R4]
                            serial_out <= comp_above; // [R1] [R22]
                            sar_q <= {sar_q[10:0], comp_above};
                            step_q <= step_q + 4'h1;
                            if (step_q < 4'd9)
                                dac_code <= next_dac(dac_code, step_q, comp_above); // [R9]
                            if (step_q == `DECISION_BITS - 1)
                            begin
                                cap_on_pos <= 1'b1; // [R14]
                                state_q <= ST_IDLE;
                                fifo_in_valid_q <= 1'b1;
                                fifo_in_data_q <= {sar_q[10:0], comp_above};
                            end
                        end
                        else
                            serial_out <= 1'b0;
                    end
                    ST_SHIFT:
                    begin
                        serial_out <= out_q[11]; // [R1]
                        out_q <= {out_q[10:0], 1'b0};
                        outcnt_q <= outcnt_q + 4'h1;
                        if (outcnt_q == `DECISION_BITS - 1)
                            state_q <= ST_IDLE;
                    end
                    default:
                    begin
                        serial_out <= 1'b0;
                    end
                endcase
            end
            // Internal clock mode: a fixed number of our own clocks per decision
            if (state_q == ST_CONV && !ext_mode_q && !powered_down)
            begin
                int_cnt_q <= int_cnt_q + 8'h01;
                if (int_cnt_q == `INT_CONV_CLKS)
                begin
                    int_cnt_q <= 8'h00;
                    sar_q <= {sar_q[10:0], comp_above};
                    step_q <= step_q + 4'h1;
                    if (step_q < 4'd9)
                        dac_code <= next_dac(dac_code, step_q, comp_above); // [R9]
                    if (step_q == `DECISION_BITS - 1)
                    begin
                        conv_strobe <= 1'b1; // [R3]
                        cap_on_pos <= 1'b1; // [R14]
                        out_q <= {sar_q[10:0], comp_above};
                        outcnt_q <= 4'h0;
                        fifo_in_valid_q <= 1'b1;
                        fifo_in_data_q <= {sar_q[10:0], comp_above};
                        state_q <= ST_SHIFT;
                    end
                end
            end
            if (state_q == ST_CONV && !ext_mode_q && powered_down)
                state_q <= ST_IDLE;
            // Unipolar and bipolar codes come straight from the comparator
            // through the DAC transfer, so the data word needs no recoding [R23] [R18]
        end
    end

    result_fifo #(
        .WIDTH(12),
        .DEPTH(DEPTH),
        .AW(5)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_data(fifo_in_data_q),
        .in_valid(fifo_in_valid_q),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready)
    );

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            result_data <= 12'h000;
            result_valid <= 1'b0;
        end
        else if (fifo_out_ready)
        begin
            result_valid <= fifo_out_valid;
            if (fifo_out_valid)
                result_data <= fifo_out_data;
        end
    end
endmodule
`default_nettype wire

// ===== sim/adc_serial_control_sva.sv
// Assertion checker for the converter serial control block
`timescale 1ns/1ns
`default_nettype none
module adc_serial_control_chk #(
    parameter DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic serial_clk,
    input wire logic select_n,
    input wire logic serial_out,
    input wire logic serial_out_oe_n,
    input wire logic conv_strobe,
    input wire logic conv_strobe_oe_n,
    input wire logic neg_is_ground,
    input wire logic track_hold,
    input wire logic input_config_sel,
    input wire logic [1:0] power_clock_sel,
    input wire logic [11:0] result_data,
    input wire logic result_valid,
    input wire logic result_ready
);
    logic sclk_q;
    logic [3:0] since_fall_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Raw pin edge; the block sees it a few clocks later
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q <= 1'b0;
            since_fall_q <= 4'hF;
        end
        else
        begin
            sclk_q <= serial_clk;
            if (sclk_q && !serial_clk)
                since_fall_q <= 4'h0;
            else if (since_fall_q != 4'hF)
                since_fall_q <= since_fall_q + 4'h1;
        end
    end
    a_out_on_fall: assert property ($changed(serial_out) && !serial_out_oe_n
        && !$past(serial_out_oe_n) |-> since_fall_q inside {[4'h1:4'h6]})
        else $error("serial_out moved away from a clock fall");
    a_out_hiz: assert property (select_n [*5] |-> serial_out_oe_n)
        else $error("serial_out driven while deselected");
    a_strobe_hiz: assert property (select_n [*5] && power_clock_sel == 2'h3
        |-> conv_strobe_oe_n) else $error("strobe driven while deselected");
    a_strobe_pulse: assert property ($rose(conv_strobe) && !conv_strobe_oe_n
        && power_clock_sel == 2'h3 |-> conv_strobe [*7] ##[1:2] !conv_strobe)
        else $error("strobe pulse not one link period");
    a_int_strobe: assert property ($fell(conv_strobe) && power_clock_sel == 2'h2
        |-> ##[1:400] conv_strobe) else $error("internal conversion never ends");
    a_track_len: assert property ($rose(track_hold) |-> ##22 track_hold
        ##[1:3] !track_hold) else $error("acquisition not three periods");
    a_hold_strobe: assert property ($fell(track_hold) && power_clock_sel[1]
        |-> ##[0:1] (conv_strobe == power_clock_sel[0]))
        else $error("conversion did not start at hold");
    a_ground_sel: assert property ($fell(track_hold)
        |-> ##[1:2] (neg_is_ground == input_config_sel))
        else $error("negative input routing wrong");
    a_fifo_hold: assert property (result_valid && !result_ready
        |=> result_valid && $stable(result_data)) else $error("result dropped");
endmodule
bind adc_serial_control adc_serial_control_chk #(.DEPTH(DEPTH)) adc_serial_control_chk_i (
    .clk(clk),
    .rst_n(rst_n),
    .serial_clk(serial_clk),
    .select_n(select_n),
    .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n),
    .conv_strobe(conv_strobe),
    .conv_strobe_oe_n(conv_strobe_oe_n),
    .neg_is_ground(neg_is_ground),
    .track_hold(track_hold),
    .input_config_sel(input_config_sel),
    .power_clock_sel(power_clock_sel),
    .result_data(result_data),
    .result_valid(result_valid),
    .result_ready(result_ready)
);
`default_nettype wire

// ===== sim/serial_host.sv
// Serial master model driving the converter's link pins
`timescale 1ns/1ns
`default_nettype none
module serial_host (
    input wire logic clk,
    output logic sclk,
    output logic sel_n,
    output logic sdi
);
    initial
    begin
        sclk = 1'b0;
        sel_n = 1'b1;
        sdi = 1'b0;
    end
    task automatic half();
    begin
        repeat (4) @(posedge clk);
        #1;
    end
    endtask
    // MSB first, clock idles low between frames
    task automatic frame(input logic [31:0] tx, input int n, input logic sel);
        int i;
    begin
        sel_n = sel;
        half();
        for (i = n - 1; i >= 0; i--)
        begin
            sdi = tx[i];
            half();
            sclk = 1'b1;
            half();
            sclk = 1'b0;
        end
        half();
        sel_n = 1'b1;
        // Released line must not keep its last value
        sdi = ~sdi;
    end
    endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the converter serial control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic result_ready = 1'b0;
    logic [9:0] vin = 10'h000;
    logic [31:0] rx_v, st_v, th_v;
    logic [9:0] exp_q[$];
    int mismatches = 0;
    int tests_run = 0;
    int i;
    wire serial_clk, select_n, serial_in, serial_out, serial_out_oe_n;
    wire conv_strobe, conv_strobe_oe_n, comp_above, neg_is_ground, track_hold;
    wire cap_on_pos, polarity_sel, input_config_sel, powered_down, result_valid;
    wire [9:0] dac_code;
    wire [3:0] pos_input, neg_input;
    wire [2:0] channel_sel;
    wire [1:0] power_clock_sel;
    wire [11:0] result_data;
    wire sdo = serial_out_oe_n ? 1'bz : serial_out;
    always #10 clk = ~clk;
    // Ideal comparator: input at or above the trial code
    assign comp_above = (vin >= dac_code);
    always @(negedge serial_clk)
    begin
        rx_v <= {rx_v[30:0], sdo};
        st_v <= {st_v[30:0], conv_strobe};
        th_v <= {th_v[30:0], track_hold};
    end
    serial_host host_i (.clk(clk), .sclk(serial_clk), .sel_n(select_n), .sdi(serial_in));
    adc_serial_control #(.DEPTH(32)) adc_serial_control_i (
        .clk(clk), .rst_n(rst_n), .serial_clk(serial_clk), .select_n(select_n),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
        .conv_strobe(conv_strobe), .conv_strobe_oe_n(conv_strobe_oe_n),
        .comp_above(comp_above), .dac_code(dac_code), .pos_input(pos_input),
        .neg_input(neg_input), .neg_is_ground(neg_is_ground), .track_hold(track_hold),
        .cap_on_pos(cap_on_pos), .channel_sel(channel_sel), .polarity_sel(polarity_sel),
        .input_config_sel(input_config_sel), .power_clock_sel(power_clock_sel),
        .powered_down(powered_down), .result_data(result_data),
        .result_valid(result_valid), .result_ready(result_ready));
    task report_and_stop;
    begin
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    // Four leading zeros ahead of the start bit, then two stuffing bytes
    task ext_conv(input logic [2:0] code, input logic se, input logic [9:0] v);
    begin
        vin = v;
        host_i.frame({8'h00, 1'b1, code, 1'b1, se, 2'h3, 16'h0000}, 28, 1'b0);
        `CHK("channel", code, channel_sel)
        `CHK("config", se, input_config_sel)
        `CHK("power", 2'h3, power_clock_sel)
        `CHK("ground", se, neg_is_ground)
        if (se)
            `CHK("pos_se", {1'b0, code[1:0], code[2]}, pos_input)
        else
            `CHK("pos_dif", {1'b0, code[1:0], code[2]}, pos_input)
        if (!se)
            `CHK("neg_dif", {1'b0, code[1:0], ~code[2]}, neg_input)
        `CHK("data", v, rx_v[14:5])
        // Earlier bits show the previous mode's idle strobe level
        `CHK("strobe", 16'h8000, st_v[15:0])
        `CHK("track", 24'h07_0000, th_v[23:0])
        `CHK("cap", 1'b1, cap_on_pos)
        exp_q.push_back(v);
    end
    endtask
    task desel;
    begin
        host_i.frame(32'h0000_00C3, 8, 1'b1);
        `CHK("ignored", 3'h0, channel_sel)
        `CHK("no_track", 8'h00, th_v[7:0])
        `CHK("oe", 2'h3, {serial_out_oe_n, conv_strobe_oe_n})
    end
    endtask
    // Far side stalls until the buffer holds all words
    task drain;
        int k;
        logic [9:0] exp_v;
    begin
        result_ready = 1'b1;
        for (k = 0; k < 100 && exp_q.size() > 0; k++)
        begin
            if (result_valid === 1'b1)
            begin
                exp_v = exp_q.pop_front();
                `CHK("fifo", exp_v, result_data[11:2])
            end
            @(posedge clk);
            #1;
        end
        result_ready = 1'b0;
        `CHK("drained", 0, exp_q.size())
        `CHK("empty", 1'b0, result_valid)
    end
    endtask
    task mode(input logic [1:0] pcs);
        int k;
    begin
        host_i.frame({24'h00_0000, 6'h2C, pcs}, 8, 1'b0);
        @(posedge clk);
        #1;
        `CHK("pcs", pcs, power_clock_sel)
        `CHK("pdown", ~pcs[1], powered_down)
        if (pcs == 2'h2)
        begin
            `CHK("busy", 2'h0, {conv_strobe, conv_strobe_oe_n})
            for (k = 0; k < 500 && !(conv_strobe === 1'b1 && result_valid === 1'b1); k++)
                @(posedge clk);
            #1;
            if (k == 500)
            begin
                mismatches++;
                report_and_stop();
            end
            `CHK("int_data", vin, result_data[11:2])
            result_ready = 1'b1;
            @(posedge clk);
            #1;
            result_ready = 1'b0;
        end
    end
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        #1;
        `CHK("reset", 7'h76, {serial_out_oe_n, conv_strobe_oe_n, conv_strobe, track_hold, cap_on_pos, neg_is_ground, result_valid})
        rst_n = 1'b1;
        ext_conv(3'h0, 1'b1, 10'h3FF);
        desel();
        for (i = 0; i < 31; i++)
            ext_conv(i[2:0], !i[3], 10'(i * 37));
        drain();
        mode(2'h2);
        mode(2'h0);
        mode(2'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
